// ==== src/ocfp_regs.vh ====
// register map, field positions, reset values and timing constants of the output clock block
`ifndef OCFP_REGS_VH
`define OCFP_REGS_VH

`define SEL_OFFSET 8'h04
`define EN_OFFSET 8'h08
`define MODE_OFFSET 8'h0C

`define SEL_RESET 16'h0000
`define EN_RESET 6'h00
`define PLL_RESET 1'b0

`define CLK_FOUR_POL_BIT 15
`define CLK_FOUR_SEL_BIT 14
`define PAIR_THREE_RATE_HI 13
`define PAIR_THREE_RATE_LO 12
`define CLK_FIVE_EN_BIT 5
`define CLK_FOUR_EN_BIT 4
`define SLAVE_PLL_BIT 0
`define MASTER_STAT_BIT 1
`define AVAIL_STAT_BIT 2

`define SYS_CLK_HZ 32'h0262_5A00
`define SYS_CLK_MHZ 32'h0000_0028
`define FRAME_US 32'h0000_007D
`define FRAME_CYCLES (`FRAME_US * `SYS_CLK_MHZ)

`define FREQ_1544K_HZ 32'h0017_8F40
`define FREQ_2048K_HZ 32'h001F_4000
`define FREQ_4096K_HZ 32'h003E_8000
`define FREQ_8192K_HZ 32'h007D_0000
`define FREQ_16384K_HZ 32'h00FA_0000
`define FREQ_32768K_HZ 32'h01F4_0000

`define PULSE_244_NS 32'h0000_00F4
`define PULSE_122_NS 32'h0000_007A
`define PULSE_61_NS 32'h0000_003D
`define PULSE_30_NS 32'h0000_001E
`define NS_TO_CYC(ns) (((ns) * `SYS_CLK_MHZ + 32'h0000_03E7) / 32'h0000_03E8)

`endif

// ==== src/output_clock_frame_pulse_ctrl.v ====
// output clock and frame pulse generator with its AHB-Lite register slave
//
// Functional notes
// - sixth clock tristated while its enable bit is low, driven when high.
// - enable bit 4 drives or tristates the fifth output clock.
// - fifth and sixth clocks run only in master mode or with slave pll enabled.
// - enable bit 3 drives or tristates fourth clock and fourth pulse together.
// - enable bit 2 drives or tristates third clock and third pulse together.
// - enable bit 1 drives or tristates second clock and second pulse together.
// - enable bit 0 drives or tristates first clock and first pulse together.
// - select bit 14 picks 2.048 MHz (clear) or 1.544 MHz (set) for fifth clock.
// - bits 13-12 pick fourth pair rate: 4.096/8.192/16.384/32.768 MHz, 244 to 30 ns.
// - clock polarity bit: falling edge on frame boundary when clear, rising when set.
// - pulse position bit: straddles boundary when clear, starts at boundary when set.
`include "ocfp_regs.vh"

module output_clock_frame_pulse_ctrl #(
   parameter [31:0] FRAME_CYCLES = `FRAME_CYCLES,
   parameter [31:0] CLK_ZERO_HZ = `FREQ_8192K_HZ,
   parameter [31:0] CLK_ONE_HZ = `FREQ_8192K_HZ,
   parameter [31:0] CLK_TWO_HZ = `FREQ_8192K_HZ,
   parameter [31:0] CLK_FIVE_HZ = `FREQ_4096K_HZ,
   parameter [31:0] PULSE_LOW_NS = `PULSE_122_NS
)(
   input wire CLK,
   input wire RESET_N,
   input wire HSEL,
   input wire [31:0] HADDR,
   input wire [1:0] HTRANS,
   input wire HWRITE,
   input wire [2:0] HSIZE,
   input wire [31:0] HWDATA,
   input wire HREADY,
   output reg [31:0] HRDATA,
   output reg HREADYOUT,
   output reg HRESP,
   input wire MASTER_MODE,
   output reg CLK_OUT_ZERO,
   output reg CLK_OUT_ZERO_OE,
   output reg CLK_OUT_ONE,
   output reg CLK_OUT_ONE_OE,
   output reg CLK_OUT_TWO,
   output reg CLK_OUT_TWO_OE,
   output reg CLK_OUT_THREE,
   output reg CLK_OUT_THREE_OE,
   output reg CLK_OUT_FOUR,
   output reg CLK_OUT_FOUR_OE,
   output reg CLK_OUT_FIVE,
   output reg CLK_OUT_FIVE_OE,
   output reg PULSE_OUT_ZERO,
   output reg PULSE_OUT_ZERO_OE,
   output reg PULSE_OUT_ONE,
   output reg PULSE_OUT_ONE_OE,
   output reg PULSE_OUT_TWO,
   output reg PULSE_OUT_TWO_OE,
   output reg PULSE_OUT_THREE,
   output reg PULSE_OUT_THREE_OE
);

////////////////////////////////////////////////////////////////////////////////

// phase increment of a numerically controlled clock, full scale 2^32
function [31:0] inc_of;
   input [31:0] hz;
   reg [63:0] t;
   begin
      t = {hz, 32'h0000_0000} / {32'h0000_0000, `SYS_CLK_HZ};
      inc_of = t[31:0];
   end
endfunction

localparam [31:0] INC_ZERO = inc_of(CLK_ZERO_HZ);
localparam [31:0] INC_ONE = inc_of(CLK_ONE_HZ);
localparam [31:0] INC_TWO = inc_of(CLK_TWO_HZ);
localparam [31:0] INC_FIVE = inc_of(CLK_FIVE_HZ);
localparam [31:0] INC_2048K = inc_of(`FREQ_2048K_HZ);
localparam [31:0] INC_1544K = inc_of(`FREQ_1544K_HZ);
localparam [31:0] INC_4096K = inc_of(`FREQ_4096K_HZ);
localparam [31:0] INC_8192K = inc_of(`FREQ_8192K_HZ);
localparam [31:0] INC_16384K = inc_of(`FREQ_16384K_HZ);
localparam [31:0] INC_32768K = inc_of(`FREQ_32768K_HZ);
localparam [31:0] W_LOW = `NS_TO_CYC(PULSE_LOW_NS);
localparam [31:0] W_244 = `NS_TO_CYC(`PULSE_244_NS);
localparam [31:0] W_122 = `NS_TO_CYC(`PULSE_122_NS);
localparam [31:0] W_61 = `NS_TO_CYC(`PULSE_61_NS);
localparam [31:0] W_30 = `NS_TO_CYC(`PULSE_30_NS);
localparam [31:0] FRAME_LAST = FRAME_CYCLES - 32'h0000_0001;

////////////////////////////////////////////////////////////////////////////////
// mode pin synchroniser

reg [2:0] mm_sync_r;
reg master_r;

always @(posedge CLK or negedge RESET_N)
begin
   if (!RESET_N)
   begin
      mm_sync_r <= 3'h0;
      master_r <= 1'b0;
   end
   else
   begin
      mm_sync_r <= {mm_sync_r[1:0], MASTER_MODE};
      // a change counts only once the second and third stages agree
      if (mm_sync_r[1] == mm_sync_r[2])
         master_r <= mm_sync_r[2];
   end
end

////////////////////////////////////////////////////////////////////////////////
// AHB-Lite slave, zero wait state

reg [15:0] sel_r;
reg [15:0] sel_nxt;
reg [5:0] en_r;
reg [5:0] en_nxt;
reg pll_r;
reg pll_nxt;
reg wr_pend_r;
reg [7:0] wr_addr_r;
reg [31:0] rd_val;
wire take = HSEL & HREADY & HTRANS[1];
wire avail = master_r | pll_r;

// a write lands in its data phase; merging it here lets a read right
// behind a write see the new value
always @*
begin
   sel_nxt = sel_r;
   en_nxt = en_r;
   pll_nxt = pll_r;
   if (wr_pend_r)
   begin
      case (wr_addr_r)
         `SEL_OFFSET: sel_nxt = HWDATA[15:0];
         `EN_OFFSET: en_nxt = HWDATA[5:0];
         `MODE_OFFSET: pll_nxt = HWDATA[`SLAVE_PLL_BIT];
         default: ;
      endcase
   end
end

always @*
begin
   case (HADDR[7:0])
      `SEL_OFFSET: rd_val = {16'h0000, sel_nxt};
      `EN_OFFSET: rd_val = {26'h000_0000, en_nxt};
      `MODE_OFFSET: rd_val = {29'h0000_0000, avail, master_r, pll_nxt};
      default: rd_val = 32'h0000_0000;
   endcase
end

always @(posedge CLK or negedge RESET_N)
begin
   if (!RESET_N)
   begin
      sel_r <= `SEL_RESET;
      en_r <= `EN_RESET;
      pll_r <= `PLL_RESET;
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      HRDATA <= 32'h0000_0000;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
   end
   else
   begin
      sel_r <= sel_nxt;
      en_r <= en_nxt;
      pll_r <= pll_nxt;
      wr_pend_r <= take & HWRITE;
      if (take)
         wr_addr_r <= HADDR[7:0];
      if (take & ~HWRITE)
         HRDATA <= rd_val;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
   end
end

////////////////////////////////////////////////////////////////////////////////
// frame timing; selections copied at the boundary only

reg [31:0] cnt_r;
reg [15:0] sel_act_r;
wire last = (cnt_r == FRAME_LAST);

always @(posedge CLK or negedge RESET_N)
begin
   if (!RESET_N)
   begin
      cnt_r <= 32'h0000_0000;
      sel_act_r <= `SEL_RESET;
   end
   else if (last)
   begin
      cnt_r <= 32'h0000_0000;
      sel_act_r <= sel_r;
   end
   else
      cnt_r <= cnt_r + 32'h0000_0001;
end

////////////////////////////////////////////////////////////////////////////////
// per-output rate, width and polarity selection

wire [1:0] rate3 = sel_act_r[`PAIR_THREE_RATE_HI:`PAIR_THREE_RATE_LO];
reg [31:0] inc3;
reg [31:0] w3;
wire [31:0] inc4 = sel_act_r[`CLK_FOUR_SEL_BIT] ? INC_1544K : INC_2048K;
wire [191:0] inc_all = {INC_FIVE, inc4, inc3, INC_TWO, INC_ONE, INC_ZERO};
wire [127:0] w_all = {w3, W_LOW, W_LOW, W_LOW};
wire [5:0] clk_pol;
wire [3:0] fp_pol;
wire [3:0] fp_pos;

always @*
begin
   case (rate3)
      2'h0:
      begin
         inc3 = INC_4096K;
         w3 = W_244;
      end
      2'h1:
      begin
         inc3 = INC_8192K;
         w3 = W_122;
      end
      2'h2:
      begin
         inc3 = INC_16384K;
         w3 = W_61;
      end
      default:
      begin
         inc3 = INC_32768K;
         w3 = W_30;
      end
   endcase
end

// sixth clock has no polarity control and keeps the falling-edge alignment
assign clk_pol[5] = 1'b0;
assign clk_pol[4] = sel_act_r[`CLK_FOUR_POL_BIT];

////////////////////////////////////////////////////////////////////////////////
// clock synthesis: phase accumulators restarted on every frame

wire [5:0] clk_v;
wire [3:0] fp_v;

genvar k;
generate
   for (k = 0; k < 6; k = k + 1)
   begin : g_clk
      reg [31:0] acc_r;
      always @(posedge CLK or negedge RESET_N)
      begin
         if (!RESET_N)
            acc_r <= 32'h0000_0000;
         else if (last)
            acc_r <= 32'h0000_0000;
         else
            acc_r <= acc_r + inc_all[32*k+31:32*k];
      end
      // msb falls as the accumulator restarts, so a clear polarity bit
      // puts the falling edge on the boundary
      assign clk_v[k] = acc_r[31] ^ clk_pol[k];
   end
   for (k = 0; k < 4; k = k + 1)
   begin : g_pair
      wire [31:0] w = w_all[32*k+31:32*k];
      wire [31:0] half = {1'b0, w[31:1]};
      wire start_win = cnt_r < w;
      wire strad_win = (cnt_r < w - half) | (cnt_r >= FRAME_CYCLES - half);
      wire active = fp_pos[k] ? start_win : strad_win;
      assign clk_pol[k] = sel_act_r[3*k+2];
      assign fp_pol[k] = sel_act_r[3*k+1];
      assign fp_pos[k] = sel_act_r[3*k];
      assign fp_v[k] = fp_pol[k] ? active : ~active;
   end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// output stage; a tristated output is also held low

always @(posedge CLK or negedge RESET_N)
begin
   if (!RESET_N)
   begin
      CLK_OUT_ZERO <= 1'b0;
      CLK_OUT_ZERO_OE <= 1'b0;
      CLK_OUT_ONE <= 1'b0;
      CLK_OUT_ONE_OE <= 1'b0;
      CLK_OUT_TWO <= 1'b0;
      CLK_OUT_TWO_OE <= 1'b0;
      CLK_OUT_THREE <= 1'b0;
      CLK_OUT_THREE_OE <= 1'b0;
      CLK_OUT_FOUR <= 1'b0;
      CLK_OUT_FOUR_OE <= 1'b0;
      CLK_OUT_FIVE <= 1'b0;
      CLK_OUT_FIVE_OE <= 1'b0;
      PULSE_OUT_ZERO <= 1'b0;
      PULSE_OUT_ZERO_OE <= 1'b0;
      PULSE_OUT_ONE <= 1'b0;
      PULSE_OUT_ONE_OE <= 1'b0;
      PULSE_OUT_TWO <= 1'b0;
      PULSE_OUT_TWO_OE <= 1'b0;
      PULSE_OUT_THREE <= 1'b0;
      PULSE_OUT_THREE_OE <= 1'b0;
   end
   else
   begin
      CLK_OUT_ZERO <= clk_v[0] & en_r[0];
      CLK_OUT_ZERO_OE <= en_r[0];
      PULSE_OUT_ZERO <= fp_v[0] & en_r[0];
      PULSE_OUT_ZERO_OE <= en_r[0];
      CLK_OUT_ONE <= clk_v[1] & en_r[1];
      CLK_OUT_ONE_OE <= en_r[1];
      PULSE_OUT_ONE <= fp_v[1] & en_r[1];
      PULSE_OUT_ONE_OE <= en_r[1];
      CLK_OUT_TWO <= clk_v[2] & en_r[2];
      CLK_OUT_TWO_OE <= en_r[2];
      PULSE_OUT_TWO <= fp_v[2] & en_r[2];
      PULSE_OUT_TWO_OE <= en_r[2];
      CLK_OUT_THREE <= clk_v[3] & en_r[3];
      CLK_OUT_THREE_OE <= en_r[3];
      PULSE_OUT_THREE <= fp_v[3] & en_r[3];
      PULSE_OUT_THREE_OE <= en_r[3];
      // unavailable clocks stay undriven even when enabled
      CLK_OUT_FOUR <= clk_v[4] & en_r[`CLK_FOUR_EN_BIT] & avail;
      CLK_OUT_FOUR_OE <= en_r[`CLK_FOUR_EN_BIT] & avail;
      CLK_OUT_FIVE <= clk_v[5] & en_r[`CLK_FIVE_EN_BIT] & avail;
      CLK_OUT_FIVE_OE <= en_r[`CLK_FIVE_EN_BIT] & avail;
   end
end

// limitation: outputs above half the system clock (32.768 MHz at
// 40 MHz) cannot be built from this clock and come out as aliased edges;
// the falling edge no longer lands on the frame boundary
endmodule // output_clock_frame_pulse_ctrl

// ==== tb/ocfp_monitor.sv ====
// checker for output enables and availability gating of the output clock block
`include "ocfp_regs.vh"
module ocfp_monitor (
   input wire CLK,
   input wire RESET_N,
   input wire HSEL,
   input wire [31:0] HADDR,
   input wire [1:0] HTRANS,
   input wire HWRITE,
   input wire [31:0] HWDATA,
   input wire HREADY,
   input wire MASTER_MODE,
   input wire CLK_OUT_FIVE,
   input wire CLK_OUT_ZERO_OE,
   input wire CLK_OUT_ONE_OE,
   input wire CLK_OUT_TWO_OE,
   input wire CLK_OUT_THREE_OE,
   input wire CLK_OUT_FOUR_OE,
   input wire CLK_OUT_FIVE_OE,
   input wire PULSE_OUT_ZERO_OE,
   input wire PULSE_OUT_ONE_OE,
   input wire PULSE_OUT_TWO_OE,
   input wire PULSE_OUT_THREE_OE
);
   timeunit 1ns;
   timeprecision 1ps;
   reg wr_pend_r;
   reg [7:0] wr_addr_r;
   reg [5:0] en_sh_r;
   reg pll_sh_r;
   default clocking @(posedge CLK); endclocking
   default disable iff (!RESET_N);
   ////////////////////////////////////////////////////////////////////////////////
   // shadow copies rebuilt from bus writes, so no internal signal is needed
   always @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= 8'h00;
         en_sh_r <= 6'h00;
         pll_sh_r <= 1'b0;
      end
      else if (HREADY)
      begin
         if (wr_pend_r && wr_addr_r == `EN_OFFSET)
            en_sh_r <= HWDATA[5:0];
         if (wr_pend_r && wr_addr_r == `MODE_OFFSET)
            pll_sh_r <= HWDATA[`SLAVE_PLL_BIT];
         wr_pend_r <= HSEL && HTRANS[1] && HWRITE;
         wr_addr_r <= HADDR[7:0];
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   a_pair_zero:
      assert property ({CLK_OUT_ZERO_OE, PULSE_OUT_ZERO_OE} == {2{$past(en_sh_r[0])}})
      else $error("pair zero enable mismatch");
   a_pair_one:
      assert property ({CLK_OUT_ONE_OE, PULSE_OUT_ONE_OE} == {2{$past(en_sh_r[1])}})
      else $error("pair one enable mismatch");
   a_pair_two:
      assert property ({CLK_OUT_TWO_OE, PULSE_OUT_TWO_OE} == {2{$past(en_sh_r[2])}})
      else $error("pair two enable mismatch");
   a_pair_three:
      assert property ({CLK_OUT_THREE_OE, PULSE_OUT_THREE_OE} == {2{$past(en_sh_r[3])}})
      else $error("pair three enable mismatch");
   a_six_off:
      assert property (!$past(en_sh_r[5]) |-> !CLK_OUT_FIVE_OE)
      else $error("sixth clock driven while disabled");
   a_six_idle:
      assert property (!CLK_OUT_FIVE_OE |-> !CLK_OUT_FIVE)
      else $error("sixth clock moves while released");
   a_five_on:
      assert property (($past(en_sh_r[4]) && $past(pll_sh_r) && $past(pll_sh_r, 2))
         |-> CLK_OUT_FOUR_OE)
      else $error("fifth clock not driven");
   a_avail_gate:
      assert property ((!pll_sh_r && !MASTER_MODE) [*8] |=> !CLK_OUT_FOUR_OE && !CLK_OUT_FIVE_OE)
      else $error("fifth or sixth clock driven while unavailable");
endmodule // ocfp_monitor

bind output_clock_frame_pulse_ctrl ocfp_monitor i_ocfp_monitor (
   .CLK(CLK), .RESET_N(RESET_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
   .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY), .MASTER_MODE(MASTER_MODE),
   .CLK_OUT_FIVE(CLK_OUT_FIVE), .CLK_OUT_ZERO_OE(CLK_OUT_ZERO_OE),
   .CLK_OUT_ONE_OE(CLK_OUT_ONE_OE), .CLK_OUT_TWO_OE(CLK_OUT_TWO_OE),
   .CLK_OUT_THREE_OE(CLK_OUT_THREE_OE), .CLK_OUT_FOUR_OE(CLK_OUT_FOUR_OE),
   .CLK_OUT_FIVE_OE(CLK_OUT_FIVE_OE), .PULSE_OUT_ZERO_OE(PULSE_OUT_ZERO_OE),
   .PULSE_OUT_ONE_OE(PULSE_OUT_ONE_OE), .PULSE_OUT_TWO_OE(PULSE_OUT_TWO_OE),
   .PULSE_OUT_THREE_OE(PULSE_OUT_THREE_OE));

// ==== tb/tdm_sink.sv ====
// downstream frame pulse consumer: counts cycles with the pulse pin high
module tdm_sink (
   input wire CLK,
   input wire clr,
   input wire pin,
   output logic [15:0] hi_cnt
);
   timeunit 1ns;
   timeprecision 1ps;
   // a released pin reads z and is never counted as high
   always @(posedge CLK)
   begin
      if (clr)
         hi_cnt <= 16'h0000;
      else if (pin === 1'b1)
         hi_cnt <= hi_cnt + 16'h0001;
   end
endmodule // tdm_sink

// ==== tb/tb_output_clock_frame_pulse_ctrl.sv ====
// self-checking testbench of the output clock and frame pulse block
`include "ocfp_regs.vh"
module tb_output_clock_frame_pulse_ctrl;
   timeunit 1ns;
   timeprecision 1ps;
   // short frame keeps the run small; widths do not depend on it
   localparam int FRAME = 200;
   logic CLK, RESET_N, HSEL, HWRITE, MASTER_MODE, clr;
   logic [31:0] HADDR, HWDATA, rd;
   logic [1:0] HTRANS;
   wire [31:0] HRDATA;
   wire HREADYOUT, HRESP, pin_three;
   wire [5:0] cko, ckoe;
   wire [3:0] fpo, fpoe;
   wire [15:0] hi_cnt;
   int failures = 0;
   int cmp_count = 0;
   int wid[4] = '{10, 5, 3, 2};
   assign pin_three = fpoe[3] ? fpo[3] : 1'bz;
   output_clock_frame_pulse_ctrl #(.FRAME_CYCLES(FRAME)) i_output_clock_frame_pulse_ctrl (
      .CLK(CLK), .RESET_N(RESET_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
      .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
      .HREADYOUT(HREADYOUT), .HRESP(HRESP), .MASTER_MODE(MASTER_MODE),
      .CLK_OUT_ZERO(cko[0]), .CLK_OUT_ZERO_OE(ckoe[0]), .CLK_OUT_ONE(cko[1]),
      .CLK_OUT_ONE_OE(ckoe[1]), .CLK_OUT_TWO(cko[2]), .CLK_OUT_TWO_OE(ckoe[2]),
      .CLK_OUT_THREE(cko[3]), .CLK_OUT_THREE_OE(ckoe[3]), .CLK_OUT_FOUR(cko[4]),
      .CLK_OUT_FOUR_OE(ckoe[4]), .CLK_OUT_FIVE(cko[5]), .CLK_OUT_FIVE_OE(ckoe[5]),
      .PULSE_OUT_ZERO(fpo[0]), .PULSE_OUT_ZERO_OE(fpoe[0]), .PULSE_OUT_ONE(fpo[1]),
      .PULSE_OUT_ONE_OE(fpoe[1]), .PULSE_OUT_TWO(fpo[2]), .PULSE_OUT_TWO_OE(fpoe[2]),
      .PULSE_OUT_THREE(fpo[3]), .PULSE_OUT_THREE_OE(fpoe[3]));
   tdm_sink i_tdm_sink (.CLK(CLK), .clr(clr), .pin(pin_three), .hi_cnt(hi_cnt));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         failures++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one single transfer; entered just after a rising edge
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
      HADDR <= a;
      HWRITE <= wr;
      HTRANS <= 2'b10;
      do @(posedge CLK); while (HREADYOUT !== 1'b1);
      HTRANS <= 2'b00;
      HWDATA <= d;
      do @(posedge CLK); while (HREADYOUT !== 1'b1);
      rd = HRDATA;
   endtask
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic test_regs();
      bus(0, `SEL_OFFSET, 0);
      check(rd, 0);
      bus(0, `MODE_OFFSET, 0);
      check(rd, 0);
      bus(1, `SEL_OFFSET, 32'hFFFF_FFFF);
      bus(0, `SEL_OFFSET, 0);
      check(rd, 32'h0000_FFFF);
      bus(1, `EN_OFFSET, 32'hFFFF_FFC0);
      bus(0, `EN_OFFSET, 0);
      check(rd, 0);
      bus(1, 32'h0000_0010, 32'hFFFF_FFFF);
      bus(0, 32'h0000_0010, 0);
      check(rd, 0);
      bus(1, `SEL_OFFSET, 0);
      $display("test_regs done");
   endtask
   task automatic test_enables();
      for (int p = 0; p < 4; p++)
      begin
         bus(1, `EN_OFFSET, 32'h1 << p);
         repeat (2) @(posedge CLK);
         check(ckoe[3:0], 4'h1 << p);
         check(fpoe, 4'h1 << p);
      end
      $display("test_enables done");
   endtask
   task automatic test_avail();
      bus(1, `EN_OFFSET, 32'h30);
      repeat (10) @(posedge CLK);
      check(ckoe[5:4], 2'b00);
      bus(1, `MODE_OFFSET, 1);
      repeat (3) @(posedge CLK);
      check(ckoe[5:4], 2'b11);
      bus(0, `MODE_OFFSET, 0);
      check(rd, 32'h5);
      MASTER_MODE <= 1'b1;
      repeat (8) @(posedge CLK);
      bus(1, `MODE_OFFSET, 0);
      repeat (8) @(posedge CLK);
      check(ckoe[5:4], 2'b11);
      bus(0, `MODE_OFFSET, 0);
      check(rd, 32'h6);
      bus(1, `EN_OFFSET, 32'h10);
      repeat (2) @(posedge CLK);
      check(ckoe[5:4], 2'b01);
      bus(1, `EN_OFFSET, 32'h20);
      repeat (2) @(posedge CLK);
      check(ckoe[5:4], 2'b10);
      $display("test_avail done");
   endtask
   // any window of one whole frame holds exactly one pulse
   task automatic test_pulse();
      bus(1, `EN_OFFSET, 32'h08);
      for (int c = 0; c < 4; c++)
         for (int pol = 0; pol < 2; pol++)
         begin
            bus(1, `SEL_OFFSET, (c << 12) | (pol << 10));
            repeat (2 * FRAME) @(posedge CLK);
            clr <= 1'b1;
            @(posedge CLK);
            clr <= 1'b0;
            repeat (FRAME) @(posedge CLK);
            #1 check(hi_cnt, pol ? wid[c] : FRAME - wid[c]);
            @(posedge CLK);
         end
      $display("test_pulse done");
   endtask
   // pair zero in start mode, active high: the pulse's first cycle is the boundary cycle
   task automatic test_edge();
      logic pf, pc;
      bus(1, `EN_OFFSET, 32'h01);
      for (int cp = 0; cp < 2; cp++)
      begin
         bus(1, `SEL_OFFSET, (cp << 2) | 3);
         repeat (2 * FRAME) @(posedge CLK);
         pf = 1'b1;
         pc = 1'b0;
         // bounded by the watchdog
         while (!(fpo[0] === 1'b1 && pf === 1'b0))
         begin
            pf = fpo[0];
            pc = cko[0];
            @(posedge CLK);
         end
         check(cko[0], cp);
         check(pc, !cp);
         repeat (4) @(posedge CLK);
         check(fpo[0], 1);
         @(posedge CLK);
         check(fpo[0], 0);
      end
      $display("test_edge done");
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      CLK = 1'b0;
      forever #12.5 CLK = ~CLK;
   end
   initial
   begin
      repeat (20000) @(posedge CLK);
      failures++;
      test_done();
   end
   initial
   begin
      RESET_N = 1'b0;
      HSEL = 1'b0;
      HADDR = 32'h0000_0000;
      HTRANS = 2'b00;
      HWRITE = 1'b0;
      HWDATA = 32'h0000_0000;
      MASTER_MODE = 1'b0;
      clr = 1'b0;
      repeat (16) @(posedge CLK);
      RESET_N <= 1'b1;
      @(posedge CLK);
      HSEL <= 1'b1;
      test_regs();
      test_enables();
      test_avail();
      test_pulse();
      test_edge();
      test_done();
   end
endmodule // tb_output_clock_frame_pulse_ctrl
